// *** hw/acr_pkg.sv ***
// register map, field layout, reset values and timing for the config bank
package acr_pkg;
    // register addresses (word addresses on the serial register port)
    localparam logic [5:0]  ADDR_IFACE_CFG   = 6'h02;
    localparam logic [5:0]  ADDR_CHAN_SAMP   = 6'h03;
    localparam logic [5:0]  ADDR_CHAN_GAIN   = 6'h04;
    // reset values
    localparam logic [15:0] RST_IFACE_CFG    = 16'h0510;
    localparam logic [15:0] RST_CHAN_SAMP    = 16'h0f0e;
    localparam logic [15:0] RST_CHAN_GAIN    = 16'h0000;
    // writable bit masks; read-only bits read as zero
    localparam logic [15:0] MASK_IFACE_CFG   = 16'hffff;
    localparam logic [15:0] MASK_CHAN_SAMP   = 16'h0fff;
    localparam logic [15:0] MASK_CHAN_GAIN   = 16'hffff;
    // interface configuration fields
    localparam int REG_CRC_BIT    = 13;
    localparam int IN_CRC_BIT     = 12;
    localparam int CRC_POLY_BIT   = 11;
    localparam int RESET_SEEN_BIT = 10;
    localparam int WORD_SIZE_HI   = 9;
    localparam int WORD_SIZE_LO   = 8;
    localparam int TIMEOUT_BIT    = 4;
    localparam int READY_SRC_HI   = 3;
    localparam int READY_SRC_LO   = 2;
    localparam int READY_IDLE_BIT = 1;
    localparam int READY_FMT_BIT  = 0;
    // channel enable and sampling fields
    localparam int CHAN_RUN_LO    = 8;
    localparam int OSR_HI         = 4;
    localparam int OSR_LO         = 2;
    localparam int PWR_HI         = 1;
    localparam int PWR_LO         = 0;
    // gain fields: channel n at bits 4n+2 .. 4n
    localparam int GAIN_STRIDE    = 4;
    // ready-source codes
    localparam logic [1:0] SRC_LAGGING = 2'h0;
    localparam logic [1:0] SRC_ANY_OR  = 2'h1;
    // power mode codes
    localparam logic [1:0] PWR_VLP     = 2'h0;
    localparam logic [1:0] PWR_LP      = 2'h1;
    // fixed ready pulse width
    localparam int READY_PULSE_NS  = 40;
    localparam int CLK_PERIOD_NS   = 10;
    localparam int READY_PULSE_CYC =
        (READY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// *** hw/acr_ready_pin.sv ***
`timescale 1ns/1ps
// data-ready pin driver: level or fixed pulse, high or released when idle
module acr_ready_pin
    import acr_pkg::*;
#(
    parameter int PULSE_CYC = READY_PULSE_CYC
)(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic ready_event,
    input  wire logic data_pending,
    input  wire logic ready_idle_state,
    input  wire logic ready_pulse_format,
    output logic      pin_out,
    output logic      pin_oe
);
    initial
    begin
        if (PULSE_CYC < 1 || PULSE_CYC > 255)
            $error("acr_ready_pin: PULSE_CYC out of range");
    end

    logic [7:0] pulse_cnt;
    logic       active_low;

    // pulse counter restarts on each new data event
    always_ff @(posedge clk)
    begin
        if (!rstn)
            pulse_cnt <= 8'h00;
        else if (ready_event)
            pulse_cnt <= PULSE_CYC[7:0];
        else if (pulse_cnt != 8'h00)
            pulse_cnt <= pulse_cnt - 8'h01;
    end

    // level while data wait, or pulse of fixed width
    always_comb
    begin
        if (ready_pulse_format)
            active_low = (pulse_cnt != 8'h00);
        else
            active_low = data_pending;
    end

    // drive low when active, else high or released
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pin_out <= 1'b1;
            pin_oe  <= 1'b1;
        end
        else
        begin
            pin_out <= !active_low;
            pin_oe  <= active_low || !ready_idle_state;
        end
    end

    chk_pulse_width: assert property (
        @(posedge clk) disable iff (!rstn)
        ready_pulse_format && ready_event ##1 ready_pulse_format
        |=> !pin_out && pin_oe)
        else $error("ready pulse did not drive low");
    chk_idle_release: assert property (
        @(posedge clk) disable iff (!rstn)
        !ready_event && !data_pending && pulse_cnt == 8'h00
        && ready_idle_state |=> !pin_oe)
        else $error("idle ready pin not released");
endmodule

// *** hw/acr_regs.sv ***
`timescale 1ns/1ps
// configuration register bank: interface, channel/sampling and gain
// Functional notes
// - register CRC check follows bit 13
// - input frame CRC only when bit 12
// - bit 11 picks CCITT or ANSI polynomial
// - reset flag set on reset, write 0 clears
// - bits 9:8 select data word size
// - serial timeout active while bit 4 set
// - bits 3:2 select ready pin source
// - idle ready pin high or released by bit 1
// - bit 0 picks ready level or pulse
// - channel runs follow bits 11:8
// - bits 4:2 set oversampling ratio
// - bits 1:0 select power mode
// - 3-bit gain fields per channel
// - registers at addresses 2h, 3h, 4h
// - reset values 510h, f0eh, 0h
module acr_regs
    import acr_pkg::*;
#(
    parameter int NUM_CHAN  = 4,
    parameter int PULSE_CYC = READY_PULSE_CYC
)(
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [5:0]  REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    output logic [15:0]      REG_RDATA,
    output logic             REG_HIT,
    input  wire logic [3:0]  CHAN_DATA_EVENT,
    input  wire logic        DATA_READ,
    output logic             STATUS_RESET_FLAG,
    output logic             REG_CRC_ON,
    output logic             IN_CRC_ON,
    output logic             CRC_POLY_ANSI,
    output logic [1:0]       WORD_SIZE_SELECT,
    output logic             SERIAL_TIMEOUT_ON,
    output logic [3:0]       CHAN_RUN,
    output logic [2:0]       OVERSAMPLING_RATIO,
    output logic [14:0]      OSR_VALUE,
    output logic [1:0]       POWER_MODE_SELECT,
    output logic [11:0]      CHAN_AMP_GAIN,
    output logic [7:0]       CHAN_GAIN_FACTOR0,
    output logic [7:0]       CHAN_GAIN_FACTOR1,
    output logic [7:0]       CHAN_GAIN_FACTOR2,
    output logic [7:0]       CHAN_GAIN_FACTOR3,
    output logic             CONVERSION_READY_PIN_O,
    output logic             CONVERSION_READY_PIN_OE
);
    initial
    begin
        if (NUM_CHAN != 4)
            $error("acr_regs: layout serves exactly four channels");
    end

    logic [15:0] interface_config;
    logic [15:0] channel_enable_sampling;
    logic [15:0] channel_gain_select;
    logic        hit_iface;
    logic        hit_samp;
    logic        hit_gain;
    logic [3:0]  pending;
    logic [3:0]  active;
    logic        ready_event;
    logic        data_pending;
    logic [1:0]  ready_source_select;
    logic        ready_idle_state;
    logic        ready_pulse_format;
    logic        lead_seen;

    // address decode of the three registers
    assign hit_iface = (REG_ADDR == ADDR_IFACE_CFG);
    assign hit_samp  = (REG_ADDR == ADDR_CHAN_SAMP);
    assign hit_gain  = (REG_ADDR == ADDR_CHAN_GAIN);
    assign REG_HIT   = hit_iface || hit_samp || hit_gain;

    // interface configuration register; reset flag set by reset
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            interface_config <= RST_IFACE_CFG;
        else if (REG_WR && hit_iface)
            interface_config <= REG_WDATA & MASK_IFACE_CFG;
    end

    // channel enable and sampling register, top nibble read-only
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            channel_enable_sampling <= RST_CHAN_SAMP;
        else if (REG_WR && hit_samp)
            channel_enable_sampling <= REG_WDATA & MASK_CHAN_SAMP;
    end

    // gain register; reserved bits stored as written
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            channel_gain_select <= RST_CHAN_GAIN;
        else if (REG_WR && hit_gain)
            channel_gain_select <= REG_WDATA & MASK_CHAN_GAIN;
    end

    // registered read data, zero for unmapped addresses
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            REG_RDATA <= 16'h0000;
        else if (REG_RD)
        begin
            if (hit_iface)
                REG_RDATA <= interface_config;
            else if (hit_samp)
                REG_RDATA <= channel_enable_sampling & MASK_CHAN_SAMP;
            else if (hit_gain)
                REG_RDATA <= channel_gain_select;
            else
                REG_RDATA <= 16'h0000;
        end
    end

    // status copy of the reset flag mirrors the config bit
    assign STATUS_RESET_FLAG = interface_config[RESET_SEEN_BIT];

    // crc and interface controls to the serial engine
    assign REG_CRC_ON        = interface_config[REG_CRC_BIT];
    assign IN_CRC_ON         = interface_config[IN_CRC_BIT];
    assign CRC_POLY_ANSI     = interface_config[CRC_POLY_BIT];
    assign WORD_SIZE_SELECT  =
        interface_config[WORD_SIZE_HI:WORD_SIZE_LO];
    assign SERIAL_TIMEOUT_ON = interface_config[TIMEOUT_BIT];
    assign ready_source_select =
        interface_config[READY_SRC_HI:READY_SRC_LO];
    assign ready_idle_state   = interface_config[READY_IDLE_BIT];
    assign ready_pulse_format = interface_config[READY_FMT_BIT];

    // converter controls
    assign CHAN_RUN =
        channel_enable_sampling[CHAN_RUN_LO+3:CHAN_RUN_LO];
    assign OVERSAMPLING_RATIO = channel_enable_sampling[OSR_HI:OSR_LO];
    assign POWER_MODE_SELECT  = channel_enable_sampling[PWR_HI:PWR_LO];

    // oversampling ratio decode; top code is 16256, not a power of two
    always_comb
    begin
        unique case (OVERSAMPLING_RATIO)
            3'h7:    OSR_VALUE = 15'h3f80;
            default: OSR_VALUE = 15'(15'h0080 << OVERSAMPLING_RATIO);
        endcase
    end

    // gain fields and their decoded factors
    assign CHAN_AMP_GAIN = {channel_gain_select[14:12],
                            channel_gain_select[10:8],
                            channel_gain_select[6:4],
                            channel_gain_select[2:0]};
    assign CHAN_GAIN_FACTOR0 = 8'(8'h01 << CHAN_AMP_GAIN[2:0]);
    assign CHAN_GAIN_FACTOR1 = 8'(8'h01 << CHAN_AMP_GAIN[5:3]);
    assign CHAN_GAIN_FACTOR2 = 8'(8'h01 << CHAN_AMP_GAIN[8:6]);
    assign CHAN_GAIN_FACTOR3 = 8'(8'h01 << CHAN_AMP_GAIN[11:9]);

    // per-channel pending data, only for running channels; read clears
    // but a new event in the same cycle wins
    assign active = CHAN_DATA_EVENT & CHAN_RUN;
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            pending <= 4'h0;
        else
            pending <= ((DATA_READ ? 4'h0 : pending) | active) & CHAN_RUN;
    end

    // first event seen since last read, for leading-channel mode
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            lead_seen <= 1'b0;
        else if (DATA_READ)
            lead_seen <= 1'b0;
        else if (active != 4'h0)
            lead_seen <= 1'b1;
    end

    // ready source: lagging waits for all enabled, or any, or leading
    always_comb
    begin
        unique case (ready_source_select)
            SRC_LAGGING: ready_event = (active != 4'h0) &&
                ((pending | active) == CHAN_RUN) &&
                (pending != CHAN_RUN);
            SRC_ANY_OR:  ready_event = (active != 4'h0);
            default:     ready_event = (active != 4'h0) &&
                !lead_seen;
        endcase
    end

    // pin level holds while any qualifying data stay unread
    always_comb
    begin
        unique case (ready_source_select)
            SRC_LAGGING: data_pending =
                (CHAN_RUN != 4'h0) && (pending == CHAN_RUN);
            default:     data_pending = (pending != 4'h0);
        endcase
    end

    acr_ready_pin #(
        .PULSE_CYC (PULSE_CYC)
    ) u_ready (
        .clk                (CLK),
        .rstn               (RSTN),
        .ready_event        (ready_event),
        .data_pending       (data_pending),
        .ready_idle_state   (ready_idle_state),
        .ready_pulse_format (ready_pulse_format),
        .pin_out            (CONVERSION_READY_PIN_O),
        .pin_oe             (CONVERSION_READY_PIN_OE)
    );

    // reset contents and reset flag
    chk_reset_values: assert property (
        @(posedge CLK)
        !RSTN |=> interface_config == RST_IFACE_CFG &&
        channel_enable_sampling == RST_CHAN_SAMP &&
        channel_gain_select == RST_CHAN_GAIN)
        else $error("reset values wrong");

    chk_reset_rdata: assert property (
        @(posedge CLK)
        !RSTN |=> REG_RDATA == 16'h0000)
        else $error("read data not cleared by reset");

    chk_flag_set: assert property (
        @(posedge CLK)
        !RSTN |=> STATUS_RESET_FLAG)
        else $error("reset flag not set by reset");

    chk_flag_clear: assert property (
        @(posedge CLK) disable iff (!RSTN)
        REG_WR && hit_iface && !REG_WDATA[10] |=> !STATUS_RESET_FLAG)
        else $error("reset flag not cleared by write of zero");

    // read-only nibble of the channel register
    chk_ro_nibble: assert property (
        @(posedge CLK) disable iff (!RSTN)
        REG_RD && hit_samp |=> REG_RDATA[15:12] == 4'h0)
        else $error("read-only nibble not zero");

    chk_ro_store: assert property (
        @(posedge CLK) disable iff (!RSTN)
        REG_WR && hit_samp |=> channel_enable_sampling[15:12] == 4'h0)
        else $error("read-only nibble stored");

    // interface controls follow a write
    chk_reg_crc: assert property (
        @(posedge CLK) disable iff (!RSTN)
        REG_WR && hit_iface |=> REG_CRC_ON == $past(REG_WDATA[13]))
        else $error("register crc enable did not follow write");

    chk_in_crc: assert property (
        @(posedge CLK) disable iff (!RSTN)
        REG_WR && hit_iface |=> IN_CRC_ON == $past(REG_WDATA[12]))
        else $error("input crc enable did not follow write");

    chk_crc_poly: assert property (
        @(posedge CLK) disable iff (!RSTN)
        REG_WR && hit_iface |=> CRC_POLY_ANSI == $past(REG_WDATA[11]))
        else $error("crc polynomial did not follow write");

    chk_word_size: assert property (
        @(posedge CLK) disable iff (!RSTN)
        REG_WR && hit_iface |=> WORD_SIZE_SELECT == $past(REG_WDATA[9:8]))
        else $error("word size did not follow write");

    chk_timeout_on: assert property (
        @(posedge CLK) disable iff (!RSTN)
        REG_WR && hit_iface |=> SERIAL_TIMEOUT_ON == $past(REG_WDATA[4]))
        else $error("timeout enable did not follow write");

    // channel runs
    chk_chan_run: assert property (
        @(posedge CLK) disable iff (!RSTN)
        REG_WR && hit_samp |=> CHAN_RUN == $past(REG_WDATA[11:8])
        ##1 (pending & ~CHAN_RUN) == 4'h0)
        else $error("channel run not applied");

    chk_run_ignore: assert property (
        @(posedge CLK) disable iff (!RSTN)
        (CHAN_DATA_EVENT & CHAN_RUN) == 4'h0 |-> !ready_event)
        else $error("stopped channel raised ready");

    // oversampling ratio field and decode
    chk_osr_field: assert property (
        @(posedge CLK) disable iff (!RSTN)
        REG_WR && hit_samp |=> OVERSAMPLING_RATIO == $past(REG_WDATA[4:2]))
        else $error("oversampling field did not follow write");

    chk_osr_low: assert property (
        @(posedge CLK) disable iff (!RSTN)
        OVERSAMPLING_RATIO == 3'h0 |-> OSR_VALUE == 15'h0080)
        else $error("lowest oversampling decode wrong");

    chk_osr_dflt: assert property (
        @(posedge CLK) disable iff (!RSTN)
        OVERSAMPLING_RATIO == 3'h3 |-> OSR_VALUE == 15'h0400)
        else $error("default oversampling decode wrong");

    chk_osr_top: assert property (
        @(posedge CLK) disable iff (!RSTN)
        OVERSAMPLING_RATIO == 3'h7 |-> OSR_VALUE == 15'h3f80)
        else $error("top oversampling decode wrong");

    chk_power_mode: assert property (
        @(posedge CLK) disable iff (!RSTN)
        REG_WR && hit_samp |=> POWER_MODE_SELECT == $past(REG_WDATA[1:0]))
        else $error("power mode did not follow write");

    // gain fields and factors
    chk_gain_map: assert property (
        @(posedge CLK) disable iff (!RSTN)
        REG_WR && hit_gain |=> CHAN_AMP_GAIN[11:9] == $past(REG_WDATA[14:12]))
        else $error("channel 3 gain field mapping wrong");

    chk_gain_low: assert property (
        @(posedge CLK) disable iff (!RSTN)
        REG_WR && hit_gain |=> CHAN_AMP_GAIN[8:0] ==
        {$past(REG_WDATA[10:8]), $past(REG_WDATA[6:4]), $past(REG_WDATA[2:0])})
        else $error("low gain fields mapping wrong");

    chk_gain_max: assert property (
        @(posedge CLK) disable iff (!RSTN)
        CHAN_AMP_GAIN[2:0] == 3'h7 |-> CHAN_GAIN_FACTOR0 == 8'h80)
        else $error("gain of 128 decode wrong");

    chk_gain_unity: assert property (
        @(posedge CLK) disable iff (!RSTN)
        CHAN_AMP_GAIN[11:9] == 3'h0 |-> CHAN_GAIN_FACTOR3 == 8'h01)
        else $error("unity gain decode wrong");

    // address decode
    chk_addr_hit: assert property (
        @(posedge CLK) disable iff (!RSTN)
        REG_HIT == (REG_ADDR inside {6'h02, 6'h03, 6'h04}))
        else $error("address decode wrong");

    chk_unmapped_rd: assert property (
        @(posedge CLK) disable iff (!RSTN)
        REG_RD && !REG_HIT |=> REG_RDATA == 16'h0000)
        else $error("unmapped read not zero");

    // ready source selection
    chk_any_or: assert property (
        @(posedge CLK) disable iff (!RSTN)
        ready_source_select == SRC_ANY_OR && !ready_pulse_format
        && (active != 4'h0) && !DATA_READ ##1 !DATA_READ
        |=> !CONVERSION_READY_PIN_O)
        else $error("or-source ready did not assert");

    chk_lag_wait: assert property (
        @(posedge CLK) disable iff (!RSTN)
        ready_source_select == SRC_LAGGING && CHAN_RUN == 4'hf
        && (pending | active) != 4'hf |-> !ready_event)
        else $error("lagging ready raised early");

    chk_lead_once: assert property (
        @(posedge CLK) disable iff (!RSTN)
        ready_source_select[1] && lead_seen |-> !ready_event)
        else $error("leading ready raised twice");
endmodule

// *** verif/acr_host.sv ***
// host controller model driving the register port and channel events
`timescale 1ns/1ps
module acr_host (
    input  wire logic        clk,
    output logic             wr,
    output logic             rd,
    output logic [5:0]       addr,
    output logic [15:0]      wdata,
    output logic [3:0]       evt,
    output logic             dread,
    input  wire logic [15:0] rdata,
    input  wire logic        hit
);
    // idle port at time zero
    initial
    begin
        {wr, rd, addr, wdata, evt, dread} = '0;
    end

    // one write, held over the taking edge; data driven as given
    task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // one read; data stands until the next read
    task automatic rd_reg(input logic [5:0] a, output logic [15:0] d,
                          output logic h);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        #1;
        h = hit;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        #1;
        d = rdata;
    endtask

    // one-cycle event or data-read pulse, then w settle cycles
    task automatic pulse(input logic [3:0] m, input logic r, input int w);
        @(posedge clk);
        evt   <= m;
        dread <= r;
        @(posedge clk);
        evt   <= 4'h0;
        dread <= 1'b0;
        repeat (w) @(posedge clk);
        #1;
    endtask
endmodule

// *** verif/adc_mode_clock_gain_regs_tb.sv ***
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
module adc_mode_clock_gain_regs_tb;
    import acr_pkg::*;
    typedef struct packed
    {
        logic [5:0]  a;
        logic [15:0] d;
        logic [15:0] q;
    } acr_row_t;

    logic        CLK, RSTN, wr, rd, dread, hit, srf, rcrc, icrc, poly;
    logic        tmo, pin_o, pin_oe, h;
    logic [5:0]  addr;
    logic [15:0] wdata, rdata, q, d;
    logic [3:0]  evt, run;
    logic [1:0]  wsz, power_mode_select;
    logic [2:0]  oversampling_ratio;
    logic [14:0] osrv;
    logic [11:0] gain;
    logic [7:0]  gf [4];
    int          error_cnt, tests_run, lows;
    // write value, expected read-back; 3h top nibble and 5h read zero
    acr_row_t    rows [5] = '{'{6'h02, 16'h0110, 16'h0110},
        '{6'h02, 16'h3f1f, 16'h3f1f}, '{6'h03, 16'hffff, 16'h0fff},
        '{6'h04, 16'h7777, 16'h7777}, '{6'h05, 16'h1234, 16'h0000}};

    acr_host u_host (.clk(CLK), .wr(wr), .rd(rd), .addr(addr),
        .wdata(wdata), .evt(evt), .dread(dread), .rdata(rdata), .hit(hit));

    acr_regs u_dut (.CLK(CLK), .RSTN(RSTN), .REG_WR(wr), .REG_RD(rd),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .REG_HIT(hit), .CHAN_DATA_EVENT(evt), .DATA_READ(dread),
        .STATUS_RESET_FLAG(srf), .REG_CRC_ON(rcrc), .IN_CRC_ON(icrc),
        .CRC_POLY_ANSI(poly), .WORD_SIZE_SELECT(wsz),
        .SERIAL_TIMEOUT_ON(tmo), .CHAN_RUN(run),
        .OVERSAMPLING_RATIO(oversampling_ratio), .OSR_VALUE(osrv),
        .POWER_MODE_SELECT(power_mode_select), .CHAN_AMP_GAIN(gain),
        .CHAN_GAIN_FACTOR0(gf[0]), .CHAN_GAIN_FACTOR1(gf[1]),
        .CHAN_GAIN_FACTOR2(gf[2]), .CHAN_GAIN_FACTOR3(gf[3]),
        .CONVERSION_READY_PIN_O(pin_o),
        .CONVERSION_READY_PIN_OE(pin_oe));

    // 100 MHz clock
    initial
    begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // compare one value and count it
    task automatic check(input string n, input logic [15:0] s, e);
        tests_run++;
        if (s !== e)
        begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask

    // verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // reset contents and pin state
    task automatic rst_chk();
        u_host.rd_reg(6'h02, q, h);
        check("rst2", q, 16'h0510);
        u_host.rd_reg(6'h03, q, h);
        check("rst3", q, 16'h0f0e);
        u_host.rd_reg(6'h04, q, h);
        check("rst4", q, 16'h0000);
        check("flag", srf, 1'b1);
        check("cfg", {rcrc, icrc, poly, wsz, tmo}, 6'h03);
        check("osrv", osrv, 16'd1024);
        check("pin", {pin_o, pin_oe}, 2'b11);
    endtask

    // hang guard
    initial
    begin
        #200000;
        error_cnt++;
        conclude();
    end

    initial
    begin
        RSTN = 1'b0;
        repeat (20) @(posedge CLK);
        RSTN <= 1'b1;
        rst_chk();
        // table rows: write, read back, decoded outputs
        foreach (rows[i])
        begin
            d = rows[i].d;
            u_host.wr_reg(rows[i].a, d);
            u_host.rd_reg(rows[i].a, q, h);
            check("rdata", q, rows[i].q);
            check("hit", h, rows[i].a inside {[2:4]});
            case (rows[i].a)
                6'h02: check("mode", {rcrc, icrc, poly, srf, wsz, tmo},
                             {d[13:8], d[4]});
                6'h03: check("run", run, d[11:8]);
                6'h04: check("gain", gain, {d[14:12], d[10:8], d[6:4],
                             d[2:0]});
                default: check("run5", run, 4'hf);
            endcase
        end
        // every ratio, power and gain code
        for (int k = 0; k < 8; k++)
        begin
            u_host.wr_reg(6'h03, {8'h0f, 3'h0, k[2:0], k[1:0]});
            u_host.wr_reg(6'h04, {4{1'b0, k[2:0]}});
            @(posedge CLK);
            #1;
            check("osr", osrv, k == 7 ? 16'd16256 : 16'd128 << k);
            check("pwr", power_mode_select, k[1:0]);
            check("osrc", oversampling_ratio, k[2:0]);
            for (int c = 0; c < 4; c++)
                check("gf", gf[c], 16'd1 << k);
        end
        // lagging source: low only once the last running channel reports
        u_host.wr_reg(6'h03, 16'h0f0e);
        u_host.wr_reg(6'h02, 16'h0010);
        u_host.pulse(4'h1, 1'b0, 4);
        u_host.pulse(4'h6, 1'b0, 4);
        check("lag", pin_o, 1'b1);
        u_host.pulse(4'h8, 1'b0, 4);
        check("lagl", {pin_o, pin_oe}, 2'b01);
        u_host.pulse(4'h0, 1'b1, 4);
        check("idleh", {pin_o, pin_oe}, 2'b11);
        // or and leading sources, released pin when idle
        for (int s = 1; s < 4; s++)
        begin
            u_host.wr_reg(6'h02, {12'h001, s[1:0], 2'b10});
            u_host.pulse(4'h4, 1'b0, 4);
            check("src", {pin_o, pin_oe}, 2'b01);
            u_host.pulse(4'h0, 1'b1, 4);
            check("hiz", pin_oe, 1'b0);
        end
        // fixed-width low pulse
        u_host.wr_reg(6'h02, 16'h0015);
        u_host.pulse(4'h2, 1'b0, 0);
        lows = 0;
        repeat (12)
        begin
            @(posedge CLK);
            #1;
            lows += int'(pin_o === 1'b0);
        end
        check("pulse", 16'(lows), 16'(READY_PULSE_CYC));
        u_host.pulse(4'h0, 1'b1, 4);
        // stopped channel is ignored
        u_host.wr_reg(6'h02, 16'h0014);
        u_host.wr_reg(6'h03, 16'h0e0e);
        u_host.pulse(4'h1, 1'b0, 4);
        check("off", pin_o, 1'b1);
        // second reset mid-run
        @(posedge CLK);
        RSTN <= 1'b0;
        repeat (2) @(posedge CLK);
        RSTN <= 1'b1;
        rst_chk();
        conclude();
    end
endmodule
